/* rtl/agr_reset_clock_ctrl_map.vh */
// Register offsets, field positions, reset values and timing for the reset/clock controller
`ifndef AGR_RESET_CLOCK_CTRL_MAP_VH
`define AGR_RESET_CLOCK_CTRL_MAP_VH

// Register byte offsets
`define AGR_OFF_CTRL 12'h000
`define AGR_OFF_FILTER 12'h004
`define AGR_OFF_GAIN 12'h008
`define AGR_OFF_STATUS 12'h00c
`define AGR_OFF_IRQ_STAT 12'h010
`define AGR_OFF_IRQ_MASK 12'h014
`define AGR_OFF_EEPROM 12'h018

// Control register fields
`define AGR_CTRL_BLANK 0
`define AGR_CTRL_PWRDN 1
`define AGR_CTRL_ERR_SET 2
`define AGR_CTRL_ERR_CLR 3

// Status register fields
`define AGR_ST_SYS_RST_N 0
`define AGR_ST_OSC_RUN 1
`define AGR_ST_BOOTING 2
`define AGR_ST_ERROR 3
`define AGR_ST_ACQ 4
`define AGR_ST_POR 5
`define AGR_ST_CMD_BUSY 6
`define AGR_ST_EXT_OSC 7

// Interrupt status and mask fields
`define AGR_IRQ_SUPPLY 0
`define AGR_IRQ_ACQ 1
`define AGR_IRQ_RX_DROP 2
`define AGR_IRQ_BAD_GAIN 3
`define AGR_IRQ_W 4

// Reset values
`define AGR_RST_FILTER 3'h0
`define AGR_RST_GAIN 16'h0001
`define AGR_RST_MASK 4'h0

// Receiver gain limits
`define AGR_GAIN_MIN 32'h0000_0001
`define AGR_GAIN_MAX 32'h0000_8000

// Board information store addressing
`define AGR_EE_TYPE 4'ha
`define AGR_EE_HW_ADDR 3'h0

// Timing: clock rate and times in microseconds
`define AGR_CLK_MHZ 100
`define AGR_POR_US 15000
`define AGR_RST_DLY_US 100
`define AGR_BOOT_US 400000
`define AGR_BLINK_US 250000
`define AGR_CNT_W 26

`endif

/* rtl/agr_reset_clock_ctrl.v */
// Reset, oscillator gating, status lights and board control outputs
`timescale 1ns/100ps
`include "agr_reset_clock_ctrl_map.vh"

// How it works
// - Supply below threshold forces system reset
// - Power-on holds reset for monitor delay
// - Switch, wake-up or acquisition pulse reset
// - Acquisition pulse holds reset unless blanked
// - Serial bytes dropped while booting
// - Power-down stops clock unless external oscillator configured, reset only exits
// - External oscillator stops during acquisition pulse
// - Pulse end restarts oscillator, delayed release
// - Blank mode ignores acquisition pulse, status bit still shows it
// - Ready light off until command acknowledged
// - Blank mode blinks error, ready on
// - Firmware error: error on, ready off
// - Both lights on at power-up, acquisition
// - Info store at hardware address zero
// - Three independent filter bits, one highpass
// - Gain accepted only within valid range
module agr_reset_clock_ctrl #(
  parameter POR_CYCLES = `AGR_POR_US * `AGR_CLK_MHZ,
  parameter RST_DLY_CYCLES = `AGR_RST_DLY_US * `AGR_CLK_MHZ,
  parameter BOOT_CYCLES = `AGR_BOOT_US * `AGR_CLK_MHZ,
  parameter BLINK_CYCLES = `AGR_BLINK_US * `AGR_CLK_MHZ
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire supply_low,
  input wire manual_reset_n,
  input wire serial_wakeup_n,
  input wire acq_pulse_n,
  input wire ext_osc_cfg,
  input wire rx_byte_valid,
  input wire [7:0] rx_byte,
  input wire cmd_rx,
  input wire cmd_ack,
  output reg rx_out_valid,
  output reg [7:0] rx_out_byte,
  output reg sys_reset_n,
  output reg osc_run,
  output reg cpu_clk_run,
  output reg ready_led,
  output reg error_led,
  output reg [2:0] filter_sel,
  output reg [15:0] rx_gain,
  output reg [7:0] board_info_store_wr_addr,
  output reg [7:0] board_info_store_rd_addr,
  output reg irq
);

  localparam NSYNC = 5;
  // Synchronisers reset to idle pin levels, so no false edge follows reset
  localparam [NSYNC-1:0] SYNC_IDLE = 5'h0e;
  // Limits cut to counter width on purpose
  localparam integer POR_M1 = POR_CYCLES - 1;
  localparam integer DLY_M1 = RST_DLY_CYCLES - 1;
  localparam integer BOOT_M1 = BOOT_CYCLES - 1;
  localparam integer BLINK_M1 = BLINK_CYCLES - 1;
  localparam [`AGR_CNT_W-1:0] POR_LIM = POR_M1[`AGR_CNT_W-1:0];
  localparam [`AGR_CNT_W-1:0] DLY_LIM = DLY_M1[`AGR_CNT_W-1:0];
  localparam [`AGR_CNT_W-1:0] BOOT_LIM = BOOT_M1[`AGR_CNT_W-1:0];
  localparam [`AGR_CNT_W-1:0] BLINK_LIM = BLINK_M1[`AGR_CNT_W-1:0];

  // Pin synchronisers
  wire [NSYNC-1:0] pin_raw;
  reg [NSYNC-1:0] sync1_r;
  reg [NSYNC-1:0] sync2_r;
  assign pin_raw = {ext_osc_cfg, acq_pulse_n, serial_wakeup_n, manual_reset_n, supply_low};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_r[gi] <= SYNC_IDLE[gi];
          sync2_r[gi] <= SYNC_IDLE[gi];
        end else if (clk_en) begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  wire sup_low_s = sync2_r[0];
  wire man_n_s = sync2_r[1];
  wire wup_n_s = sync2_r[2];
  wire acq_act = ~sync2_r[3];
  wire ext_cfg_s = sync2_r[4];

  // Software state
  reg blank_r;
  reg pwrdn_r;
  reg err_r;
  reg cmd_busy_r;
  reg [`AGR_IRQ_W-1:0] irq_stat_r;
  reg [`AGR_IRQ_W-1:0] irq_mask_r;
  reg [`AGR_IRQ_W-1:0] irq_stat_nxt;

  // Reset sequencing state
  reg por_r;
  reg booting_r;
  reg [`AGR_CNT_W-1:0] rst_cnt_r;
  reg [`AGR_CNT_W-1:0] boot_cnt_r;
  reg [`AGR_CNT_W-1:0] blink_cnt_r;
  reg blink_r;
  reg sup_low_d_r;
  reg acq_rst_d_r;

  wire acq_rst = acq_act & ~blank_r;
  wire rst_src = sup_low_s | ~man_n_s | ~wup_n_s | acq_rst;
  wire [`AGR_CNT_W-1:0] rst_lim = por_r ? POR_LIM : DLY_LIM;
  wire rx_ok = sys_reset_n & ~booting_r;
  wire both_on = por_r | (~sys_reset_n & acq_rst);

  // APB decode
  wire acc = psel & penable & ~pready;
  wire wr = acc & pwrite;
  wire [31:0] wd = pwdata;
  wire is_ctrl = (paddr == `AGR_OFF_CTRL);
  wire is_filt = (paddr == `AGR_OFF_FILTER);
  wire is_gain = (paddr == `AGR_OFF_GAIN);
  wire is_stat = (paddr == `AGR_OFF_STATUS);
  wire is_istat = (paddr == `AGR_OFF_IRQ_STAT);
  wire is_imask = (paddr == `AGR_OFF_IRQ_MASK);
  wire is_ee = (paddr == `AGR_OFF_EEPROM);
  wire mapped = is_ctrl | is_filt | is_gain | is_stat | is_istat | is_imask | is_ee;
  wire gain_ok = (wd >= `AGR_GAIN_MIN) && (wd <= `AGR_GAIN_MAX);
  wire bad_gain = wr & is_gain & ~gain_ok;

  // System reset generator
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset_n <= 1'b0;
      por_r <= 1'b1;
      rst_cnt_r <= {`AGR_CNT_W{1'b0}};
    end else if (clk_en) begin
      // Any source restarts the release delay
      if (rst_src) begin
        sys_reset_n <= 1'b0;
        rst_cnt_r <= {`AGR_CNT_W{1'b0}};
      end else if (!sys_reset_n) begin
        if (rst_cnt_r >= rst_lim) begin
          sys_reset_n <= 1'b1;
          por_r <= 1'b0;
        end else begin
          rst_cnt_r <= rst_cnt_r + 1'b1;
        end
      end
    end
  end

  // Boot window after each release
  // Serial bytes and commands are refused until it ends
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      booting_r <= 1'b1;
      boot_cnt_r <= {`AGR_CNT_W{1'b0}};
    end else if (clk_en) begin
      if (!sys_reset_n) begin
        booting_r <= 1'b1;
        boot_cnt_r <= {`AGR_CNT_W{1'b0}};
      end else if (booting_r) begin
        if (boot_cnt_r >= BOOT_LIM)
          booting_r <= 1'b0;
        else
          boot_cnt_r <= boot_cnt_r + 1'b1;
      end
    end
  end

  // Serial byte gate
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_out_valid <= 1'b0;
      rx_out_byte <= 8'h00;
    end else if (clk_en) begin
      rx_out_valid <= rx_byte_valid & rx_ok;
      if (rx_byte_valid & rx_ok)
        rx_out_byte <= rx_byte;
    end
  end

  // Oscillator and processor clock control
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_run <= 1'b1;
      cpu_clk_run <= 1'b1;
    end else if (clk_en) begin
      osc_run <= ~(ext_cfg_s & acq_rst);
      cpu_clk_run <= ~(~ext_cfg_s & pwrdn_r);
    end
  end

  // Blink timer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_r <= {`AGR_CNT_W{1'b0}};
      blink_r <= 1'b0;
    end else if (clk_en) begin
      if (!blank_r) begin
        blink_cnt_r <= {`AGR_CNT_W{1'b0}};
        blink_r <= 1'b0;
      end else if (blink_cnt_r >= BLINK_LIM) begin
        blink_cnt_r <= {`AGR_CNT_W{1'b0}};
        blink_r <= ~blink_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + 1'b1;
      end
    end
  end

  // Command activity, set wins over acknowledge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cmd_busy_r <= 1'b0;
    else if (clk_en) begin
      if (cmd_rx & rx_ok)
        cmd_busy_r <= 1'b1;
      else if (cmd_ack | ~sys_reset_n)
        cmd_busy_r <= 1'b0;
    end
  end

  // Status lights
  // Power-on and acquisition reset win over error and blank
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_led <= 1'b1;
      error_led <= 1'b1;
    end else if (clk_en) begin
      if (both_on) begin
        ready_led <= 1'b1;
        error_led <= 1'b1;
      end else if (err_r) begin
        ready_led <= 1'b0;
        error_led <= 1'b1;
      end else if (blank_r) begin
        ready_led <= 1'b1;
        error_led <= blink_r;
      end else begin
        ready_led <= ~cmd_busy_r;
        error_led <= 1'b0;
      end
    end
  end

  // Control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_r <= 1'b0;
      pwrdn_r <= 1'b0;
      err_r <= 1'b0;
      filter_sel <= `AGR_RST_FILTER;
      rx_gain <= `AGR_RST_GAIN;
      irq_mask_r <= `AGR_RST_MASK;
    end else if (clk_en) begin
      if (wr & is_ctrl) begin
        blank_r <= wd[`AGR_CTRL_BLANK];
        if (wd[`AGR_CTRL_PWRDN])
          pwrdn_r <= 1'b1;
      end else if (!sys_reset_n) begin
        // Power-down is left only through a system reset
        pwrdn_r <= 1'b0;
      end
      if (wr & is_ctrl & wd[`AGR_CTRL_ERR_SET])
        err_r <= 1'b1;
      else if (wr & is_ctrl & wd[`AGR_CTRL_ERR_CLR])
        err_r <= 1'b0;
      if (wr & is_filt)
        filter_sel <= wd[2:0];
      if (wr & is_gain & gain_ok)
        rx_gain <= wd[15:0];
      if (wr & is_imask)
        irq_mask_r <= wd[`AGR_IRQ_W-1:0];
    end
  end

  // Interrupt status, event set wins over write-one clear
  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (wr & is_istat)
      irq_stat_nxt = irq_stat_nxt & ~wd[`AGR_IRQ_W-1:0];
    if (sup_low_s & ~sup_low_d_r)
      irq_stat_nxt[`AGR_IRQ_SUPPLY] = 1'b1;
    if (acq_rst & ~acq_rst_d_r)
      irq_stat_nxt[`AGR_IRQ_ACQ] = 1'b1;
    if (rx_byte_valid & ~rx_ok)
      irq_stat_nxt[`AGR_IRQ_RX_DROP] = 1'b1;
    if (bad_gain)
      irq_stat_nxt[`AGR_IRQ_BAD_GAIN] = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= {`AGR_IRQ_W{1'b0}};
      sup_low_d_r <= 1'b0;
      acq_rst_d_r <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      irq_stat_r <= irq_stat_nxt;
      sup_low_d_r <= sup_low_s;
      acq_rst_d_r <= acq_rst;
      irq <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // Board information store device addresses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      board_info_store_wr_addr <= 8'h00;
      board_info_store_rd_addr <= 8'h00;
    end else if (clk_en) begin
      board_info_store_wr_addr <= {`AGR_EE_TYPE, `AGR_EE_HW_ADDR, 1'b0};
      board_info_store_rd_addr <= {`AGR_EE_TYPE, `AGR_EE_HW_ADDR, 1'b1};
    end
  end

  // APB slave, one wait state
  // Writes land at the first access edge, pready follows a cycle later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      pready <= acc;
      pslverr <= acc & (~mapped | bad_gain);
      prdata <= 32'h0000_0000;
      if (acc & ~pwrite) begin
        if (is_ctrl) begin
          prdata[`AGR_CTRL_BLANK] <= blank_r;
          prdata[`AGR_CTRL_PWRDN] <= pwrdn_r;
          prdata[`AGR_CTRL_ERR_SET] <= err_r;
        end else if (is_filt) begin
          prdata[2:0] <= filter_sel;
        end else if (is_gain) begin
          prdata[15:0] <= rx_gain;
        end else if (is_stat) begin
          prdata[`AGR_ST_SYS_RST_N] <= sys_reset_n;
          prdata[`AGR_ST_OSC_RUN] <= osc_run;
          prdata[`AGR_ST_BOOTING] <= booting_r;
          prdata[`AGR_ST_ERROR] <= err_r;
          prdata[`AGR_ST_ACQ] <= acq_act;
          prdata[`AGR_ST_POR] <= por_r;
          prdata[`AGR_ST_CMD_BUSY] <= cmd_busy_r;
          prdata[`AGR_ST_EXT_OSC] <= ext_cfg_s;
        end else if (is_istat) begin
          prdata[`AGR_IRQ_W-1:0] <= irq_stat_r;
        end else if (is_imask) begin
          prdata[`AGR_IRQ_W-1:0] <= irq_mask_r;
        end else if (is_ee) begin
          prdata[7:0] <= board_info_store_wr_addr;
          prdata[15:8] <= board_info_store_rd_addr;
        end
      end
    end
  end

endmodule

/* tb/agr_rcc_monitor.sv */
// Concurrent checks on the reset and clock controller ports
`timescale 1ns/100ps
module agr_rcc_monitor #(
  parameter POR_CYCLES = 20,
  parameter RST_DLY_CYCLES = 8,
  parameter BOOT_CYCLES = 16,
  parameter BLINK_CYCLES = 4
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic pready,
  input logic pslverr,
  input logic supply_low,
  input logic manual_reset_n,
  input logic serial_wakeup_n,
  input logic acq_pulse_n,
  input logic ext_osc_cfg,
  input logic rx_byte_valid,
  input logic rx_out_valid,
  input logic sys_reset_n,
  input logic osc_run,
  input logic ready_led,
  input logic error_led,
  input logic [7:0] board_info_store_wr_addr,
  input logic [7:0] board_info_store_rd_addr
);
  logic blank_r, err_r, seen_r, led_r;
  logic [7:0] quiet_r, boot_r, still_r;
  wire ctl_wr = psel && penable && pready && pwrite && paddr == 12'h000;
  wire src = supply_low || !manual_reset_n || !serial_wakeup_n || (!acq_pulse_n && !blank_r);
  // Track blank and error from control writes, count quiet, boot and steady-light cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_r <= 1'b0;
      err_r <= 1'b0;
      seen_r <= 1'b0;
      led_r <= 1'b0;
      quiet_r <= 8'h00;
      boot_r <= 8'h00;
      still_r <= 8'h00;
    end else begin
      if (ctl_wr) begin
        blank_r <= pwdata[0];
        err_r <= pwdata[2] | (err_r & ~pwdata[3]);
      end
      seen_r <= seen_r | sys_reset_n;
      led_r <= error_led;
      quiet_r <= src ? 8'h00 : quiet_r + {7'h00, quiet_r != 8'hff};
      boot_r <= !sys_reset_n ? 8'h00 : boot_r + {7'h00, boot_r != 8'hff};
      still_r <= (error_led != led_r) ? 8'h00 : still_r + {7'h00, still_r != 8'hff};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_quiet;
    (acq_pulse_n && manual_reset_n && serial_wakeup_n && !supply_low)[*8];
  endsequence
  sequence s_acq;
    (!acq_pulse_n && !blank_r)[*4];
  endsequence
  a_src_reset: assert property (
    (supply_low || !manual_reset_n || !serial_wakeup_n)[*3] |=> !sys_reset_n)
    else $error("reset source did not pull system reset low");
  a_acq_hold: assert property (
    s_acq |=> !sys_reset_n && osc_run == !ext_osc_cfg)
    else $error("acquisition pulse did not hold reset or gate oscillator");
  a_acq_lights: assert property (s_acq ##1 1'b1 |=> ready_led && error_led)
    else $error("lights not both on during acquisition reset");
  a_blank_ignore: assert property (
    (blank_r && sys_reset_n && !src)[*4] |=> sys_reset_n && osc_run)
    else $error("blank mode did not ignore acquisition pulse");
  a_osc_restart: assert property ($rose(acq_pulse_n) |-> ##[1:4] osc_run)
    else $error("oscillator not restarted after pulse end");
  a_release_delay: assert property (
    $rose(sys_reset_n) |-> quiet_r >= (seen_r ? RST_DLY_CYCLES : POR_CYCLES))
    else $error("system reset released too early");
  a_release_bound: assert property (
    seen_r ##0 s_quiet |-> ##[0:12] sys_reset_n)
    else $error("system reset not released in time");
  a_rx_drop: assert property (
    rx_byte_valid && boot_r < BOOT_CYCLES |=> !rx_out_valid)
    else $error("byte passed during reset or boot");
  a_gain_range: assert property (
    psel && penable && pready && pwrite && paddr == 12'h008 |->
    pslverr == (pwdata == 32'h0000_0000 || pwdata > 32'h0000_8000))
    else $error("gain range response wrong");
  a_info_addr: assert property (
    $past(presetn, 2) |-> board_info_store_wr_addr == 8'ha0 && board_info_store_rd_addr == 8'ha1)
    else $error("info store address wrong");
  a_err_led: assert property (
    ctl_wr && pwdata[2] && seen_r && sys_reset_n && acq_pulse_n |-> ##[1:3] error_led && !ready_led)
    else $error("error lights wrong");
  a_blink: assert property (
    (blank_r && !err_r && sys_reset_n)[*8] |-> ready_led && still_r < BLINK_CYCLES + 2)
    else $error("blank mode lights wrong");
endmodule
bind agr_reset_clock_ctrl agr_rcc_monitor #(.POR_CYCLES(POR_CYCLES),
  .RST_DLY_CYCLES(RST_DLY_CYCLES), .BOOT_CYCLES(BOOT_CYCLES), .BLINK_CYCLES(BLINK_CYCLES))
  mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .supply_low(supply_low),
  .manual_reset_n(manual_reset_n), .serial_wakeup_n(serial_wakeup_n),
  .acq_pulse_n(acq_pulse_n), .ext_osc_cfg(ext_osc_cfg), .rx_byte_valid(rx_byte_valid),
  .rx_out_valid(rx_out_valid), .sys_reset_n(sys_reset_n), .osc_run(osc_run),
  .ready_led(ready_led), .error_led(error_led),
  .board_info_store_wr_addr(board_info_store_wr_addr),
  .board_info_store_rd_addr(board_info_store_rd_addr));

/* tb/agr_acq_partner.sv */
// Acquisition controller model driving the acquisition pulse and wake-up line
`timescale 1ns/100ps
module agr_acq_partner (
  input wire logic pclk,
  input wire logic go,
  input wire logic kind,
  input wire logic [7:0] len,
  output logic acq_pulse_n,
  output logic serial_wakeup_n
);
  logic [7:0] cnt_r = 8'h00;
  logic sel_r = 1'b0;
  always @(posedge pclk) begin
    if (go && cnt_r == 8'h00) begin
      cnt_r <= len;
      sel_r <= kind;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  // Lines low only while the count runs
  assign acq_pulse_n = !(cnt_r != 8'h00 && !sel_r);
  assign serial_wakeup_n = !(cnt_r != 8'h00 && sel_r);
endmodule

/* tb/tb.sv */
// Self-checking testbench for the reset and clock controller
`timescale 1ns/100ps
module tb;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, v;
  logic supply_low = 0, manual_reset_n = 1, ext_osc_cfg = 0, rx_byte_valid = 0, cmd_rx = 0;
  logic cmd_ack = 0, go = 0, kind = 0, rx_out_valid, sys_reset_n, osc_run, cpu_clk_run;
  logic ready_led, error_led, irq, acq_pulse_n, serial_wakeup_n;
  logic [7:0] rx_byte = 0, len = 8'h10, rx_out_byte, board_info_store_wr_addr;
  logic [7:0] board_info_store_rd_addr;
  logic [2:0] filter_sel, mf;
  logic [15:0] rx_gain;
  int miscompares = 0, checks_done = 0, seed = 8099, i, mg = 1;
  int gt[5] = '{0, 1, 32768, 32769, 777};
  always #5 pclk = ~pclk;
  agr_acq_partner pm (.pclk(pclk), .go(go), .kind(kind), .len(len), .acq_pulse_n(acq_pulse_n),
    .serial_wakeup_n(serial_wakeup_n));
  agr_reset_clock_ctrl #(.POR_CYCLES(20), .RST_DLY_CYCLES(8), .BOOT_CYCLES(16),
    .BLINK_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_low(supply_low),
    .manual_reset_n(manual_reset_n), .serial_wakeup_n(serial_wakeup_n),
    .acq_pulse_n(acq_pulse_n), .ext_osc_cfg(ext_osc_cfg), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .cmd_rx(cmd_rx), .cmd_ack(cmd_ack), .rx_out_valid(rx_out_valid),
    .rx_out_byte(rx_out_byte), .sys_reset_n(sys_reset_n), .osc_run(osc_run),
    .cpu_clk_run(cpu_clk_run), .ready_led(ready_led), .error_led(error_led),
    .filter_sel(filter_sel), .rx_gain(rx_gain),
    .board_info_store_wr_addr(board_info_store_wr_addr),
    .board_info_store_rd_addr(board_info_store_rd_addr), .irq(irq));
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("miscompares %0d checks_done %0d", miscompares, checks_done);
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task hang;
    miscompares++;
    stop_test;
  endtask
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
    input logic ee);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) hang();
    chk(pslverr, ee);
    if (!w) chk(prdata, e);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task wsr(input logic x);
    for (int n = 0; sys_reset_n !== x; n++) begin
      if (n == 300) hang();
      @(posedge pclk);
    end
  endtask
  task pulse(input logic k);
    kind <= k;
    len <= 8'h0c + 8'($random(seed) & 15);
    go <= 1;
    @(posedge pclk);
    go <= 0;
    repeat (6) @(posedge pclk);
  endtask
  task snd(input logic [7:0] b, input logic ex);
    rx_byte_valid <= 1;
    rx_byte <= b;
    @(posedge pclk);
    rx_byte_valid <= 0;
    @(posedge pclk);
    chk(rx_out_valid, ex);
    if (ex) chk(rx_out_byte, b);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    chk({ready_led, error_led, sys_reset_n}, 3'b110);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    acc(0, 12'h018, 0, 32'h0000_a1a0, 0);
    wsr(1);
    snd(8'h5a, 0);
    for (i = 0; i < 5; i++) begin
      if (i == 4) gt[i] = {$random(seed)} % 40000;
      acc(1, 12'h008, gt[i], 0, gt[i] < 1 || gt[i] > 32768);
      if (gt[i] >= 1 && gt[i] <= 32768) mg = gt[i];
      chk(rx_gain, mg);
      acc(0, 12'h008, 0, mg, 0);
    end
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      mf = v[2:0];
      acc(1, 12'h004, v, 0, 0);
      chk(filter_sel, mf);
      acc(0, 12'h004, 0, mf, 0);
    end
    acc(0, 12'h0fc, 0, 0, 1);
    repeat (20) @(posedge pclk);
    snd(8'ha5, 1);
    chk(irq, 0);
    acc(1, 12'h014, 32'h0000_000c, 0, 0);
    repeat (2) @(posedge pclk);
    chk(irq, 1);
    acc(0, 12'h010, 0, 32'h0000_000c, 0);
    acc(1, 12'h010, 32'h0000_000c, 0, 0);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    acc(1, 12'h000, 32'h0000_0002, 0, 0);
    repeat (2) @(posedge pclk);
    chk(cpu_clk_run, 0);
    for (i = 0; i < 3; i++) begin
      if (i == 0) supply_low <= 1;
      if (i == 1) manual_reset_n <= 0;
      if (i == 2) pulse(1);
      else repeat (6) @(posedge pclk);
      chk(sys_reset_n, 0);
      chk(cpu_clk_run, 1);
      supply_low <= 0;
      manual_reset_n <= 1;
      wsr(1);
    end
    ext_osc_cfg <= 1;
    repeat (4) @(posedge pclk);
    pulse(0);
    chk({sys_reset_n, osc_run, ready_led, error_led}, 4'b0011);
    wsr(1);
    chk(osc_run, 1);
    repeat (30) @(posedge pclk);
    acc(1, 12'h000, 32'h0000_0001, 0, 0);
    pulse(0);
    v = 0;
    for (i = 0; i < 12; i++) begin
      @(posedge pclk);
      v[i] = error_led;
    end
    chk({sys_reset_n, osc_run, ready_led}, 3'b111);
    chk(&v[11:0] | ~|v[11:0], 0);
    // Let the blanked pulse end before blank mode is left
    repeat (20) @(posedge pclk);
    acc(1, 12'h000, 32'h0000_0004, 0, 0);
    repeat (2) @(posedge pclk);
    chk({error_led, ready_led}, 2'b10);
    acc(1, 12'h000, 32'h0000_0008, 0, 0);
    repeat (2) @(posedge pclk);
    chk({error_led, ready_led}, 2'b01);
    cmd_rx <= 1;
    @(posedge pclk);
    cmd_rx <= 0;
    repeat (3) @(posedge pclk);
    chk(ready_led, 0);
    cmd_ack <= 1;
    @(posedge pclk);
    cmd_ack <= 0;
    repeat (3) @(posedge pclk);
    chk(ready_led, 1);
    acc(0, 12'h00c, 0, 32'h0000_0083, 0);
    clk_en <= 0;
    cmd_rx <= 1;
    repeat (3) @(posedge pclk);
    chk(ready_led, 1);
    cmd_rx <= 0;
    clk_en <= 1;
    repeat (3) @(posedge pclk);
    chk(ready_led, 1);
    stop_test;
  end
endmodule
